// ---- hw/gauge_measurement_sequencer.sv ----
// Measurement sequencer, result handling and charge accumulation
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Sequence repeats continuously while active.
// - Divider supply switched on a settle time before each aux conversion.
// - Divider supply stays off during the temperature slot.
// - One full sequence takes 1760 ms.
// - Voltage refreshed every 880 ms, two's complement.
// - Voltage above maximum loads 7FFFh.
// - Every 1024th conversion measures offset; correction used after.
// - Calibration conversion leaves voltage result unchanged.
// - Calibration conversion leaves current result unchanged.
// - Aux inputs alternate, each refreshed every 1760 ms.
// - Temperature refreshed every 1760 ms, two's complement.
// - Temperature replaces second aux only while select bit set.
// - Current positive when sense pin below ground.
// - Sense sampled differentially, +-51.2 mV in 25 uV steps.
// - Current refreshed every 880 ms at end of conversion.
// - Current clamps to 7FFFh and 8000h beyond limits.
// - Bias added to raw current for result, accumulator, blanking.
// - Bias readable, writable, applies to every later sample.
// - Bias is a two's complement byte, default zero.
// - Biased current added to signed accumulator, +-204.8 mVh.
// - Accumulated charge scaled by initial or learned capacity factor.
// - Sleep: no conversions or accumulation; results stay writable.
// - Current below blanking threshold is not accumulated.
module gauge_measurement_sequencer
   import gauge_seq_pkg::*;
#(
   parameter int MS_CYCLES = CYC_PER_MS
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // Mode and configuration
   input  wire logic                 activeMode,
   input  wire logic                 internalTempSelect,
   input  wire logic [7:0]           blankThreshold,
   input  wire logic [7:0]           capScaleInitial,
   input  wire logic [7:0]           capScaleLearned,
   input  wire logic                 learnedValid,
   // Host result writes
   input  wire logic                 wrEn,
   input  wire logic [2:0]           wrSel,
   input  wire logic [15:0]          wrData,
   // Converter
   output logic                      convStart,
   output var gauge_seq_pkg::chan_t  convChan,
   input  wire logic                 convDone,
   input  wire logic signed [15:0]   convData,
   // Divider supply pin
   output logic                      dividerSupplyOut,
   // Results
   output logic signed [15:0]        voltResult,
   output logic signed [15:0]        currResult,
   output logic signed [15:0]        auxAResult,
   output logic signed [15:0]        auxBResult,
   output logic signed [15:0]        tempResult,
   output logic signed [7:0]         currentOffsetBias,
   output logic signed [31:0]        chargeAccumulator,
   output logic signed [40:0]        capacityDelta
);
   import gauge_seq_pkg::*;

   // Settling is counted in whole cycles so that its length never depends
   // on where the millisecond enable happens to fall
   localparam logic [17:0] SETTLE_LAST = 18'(SETTLE_MS * MS_CYCLES - 1);

   state_t             state_r;
   state_t             state_nxt;
   logic [16:0]        msCnt_r;
   logic               msTick;
   logic [9:0]         halfCnt_r;
   logic               halfDue_r;
   logic [17:0]        settleCnt_r;
   logic               halfSel_r;
   logic               convBusy_r;
   logic               calThis_r;
   logic [9:0]         convCount_r;
   logic signed [15:0] offset_r;
   logic               convIsCal;
   logic               tempSlot;
   logic               done;
   logic signed [16:0] voltCorr;
   logic signed [17:0] currBiased;
   logic signed [15:0] currClamp;
   logic [17:0]        currMag;
   logic signed [32:0] accSum;

   ////////////////////////////////////////////////////////////////////
   // Time base: 1 ms enable and 880 ms half-sequence timer
   assign msTick = (msCnt_r == 17'(MS_CYCLES - 1));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         msCnt_r <= '0;
      end else if (!activeMode || msTick) begin
         msCnt_r <= '0;
      end else begin
         msCnt_r <= msCnt_r + 17'd1;
      end
   end

   // Each half holds voltage, current and one aux slot
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         halfCnt_r <= '0;
      end else if (!activeMode) begin
         halfCnt_r <= '0;
      end else if (msTick) begin
         halfCnt_r <= (halfCnt_r == HALF_TICKS - 10'd1) ? 10'd0
                    : halfCnt_r + 10'd1;
      end
   end

   // Set wins over the clear so a late sequence never loses its start
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         halfDue_r <= 1'b0;
      end else if (!activeMode) begin
         halfDue_r <= 1'b0;
      end else if (msTick && halfCnt_r == HALF_TICKS - 10'd1) begin
         halfDue_r <= 1'b1;
      end else if (state_r == S_WAIT) begin
         halfDue_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   assign done      = convBusy_r && convDone;
   assign tempSlot  = halfSel_r && internalTempSelect;
   assign convIsCal = (convCount_r == CAL_SLOT);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         S_SLEEP: if (activeMode) state_nxt = S_WAIT;
         S_WAIT:  if (halfDue_r)  state_nxt = S_VOLT;
         S_VOLT:  if (done)       state_nxt = S_CURR;
         S_CURR:  if (done)       state_nxt = tempSlot ? S_AUX : S_PRE;
         S_PRE: begin
            if (settleCnt_r == SETTLE_LAST) begin
               state_nxt = S_AUX;
            end
         end
         S_AUX:   if (done)       state_nxt = S_WAIT;
         default:                 state_nxt = S_SLEEP;
      endcase
      if (!activeMode && !convBusy_r) begin
         state_nxt = S_SLEEP;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_SLEEP;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         settleCnt_r <= '0;
      end else if (state_r != S_PRE) begin
         settleCnt_r <= '0;
      end else begin
         settleCnt_r <= settleCnt_r + 18'd1;
      end
   end

   // Aux inputs alternate between halves
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         halfSel_r <= 1'b0;
      end else if (state_r == S_AUX && done) begin
         halfSel_r <= ~halfSel_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Converter handshake and shared conversion counter
   assign convStart = activeMode && !convBusy_r
                    && (state_r == S_VOLT || state_r == S_CURR
                        || state_r == S_AUX);

   always_comb begin
      if (convIsCal) begin
         convChan = CH_CAL;
      end else if (state_r == S_VOLT) begin
         convChan = CH_VOLT;
      end else if (state_r == S_CURR) begin
         convChan = CH_CURR;
      end else if (tempSlot) begin
         convChan = CH_TEMP;
      end else begin
         convChan = halfSel_r ? CH_AUXB : CH_AUXA;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         convBusy_r <= 1'b0;
         calThis_r  <= 1'b0;
      end else if (convStart) begin
         convBusy_r <= 1'b1;
         calThis_r  <= convIsCal;
      end else if (convDone) begin
         convBusy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         convCount_r <= '0;
      end else if (done) begin
         convCount_r <= convCount_r + 10'd1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         offset_r <= '0;
      end else if (done && calThis_r) begin
         offset_r <= convData;
      end
   end

   // Divider is driven only for ratiometric aux slots
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dividerSupplyOut <= 1'b0;
      end else begin
         dividerSupplyOut <= (state_nxt == S_PRE)
                          || (state_nxt == S_AUX && !tempSlot);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Result arithmetic
   assign voltCorr = 17'(convData) - 17'(offset_r);
   // Converter reports sense minus ground, so the sign is flipped
   assign currBiased = -18'(convData) - 18'(offset_r)
                     + 18'(currentOffsetBias);
   always_comb begin
      if (currBiased > CURR_MAX) begin
         currClamp = POS_FULL;
      end else if (currBiased < CURR_MIN) begin
         currClamp = NEG_FULL;
      end else begin
         currClamp = currBiased[15:0];
      end
   end
   assign currMag = currBiased[17] ? -currBiased : currBiased;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         voltResult <= RESULT_RST;
      end else if (wrEn && wrSel == WR_VOLT) begin
         voltResult <= wrData;
      end else if (done && !calThis_r && state_r == S_VOLT) begin
         voltResult <= (voltCorr > VOLT_MAX) ? POS_FULL
                     : voltCorr[15:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         currResult <= RESULT_RST;
      end else if (wrEn && wrSel == WR_CURR) begin
         currResult <= wrData;
      end else if (done && !calThis_r && state_r == S_CURR) begin
         currResult <= currClamp;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         auxAResult <= RESULT_RST;
         auxBResult <= RESULT_RST;
         tempResult <= RESULT_RST;
      end else begin
         if (wrEn && wrSel == WR_AUXA) begin
            auxAResult <= wrData;
         end else if (done && !calThis_r && state_r == S_AUX
                      && !halfSel_r) begin
            auxAResult <= convData - offset_r;
         end
         if (wrEn && wrSel == WR_AUXB) begin
            auxBResult <= wrData;
         end else if (done && !calThis_r && state_r == S_AUX
                      && halfSel_r && !tempSlot) begin
            auxBResult <= convData - offset_r;
         end
         if (wrEn && wrSel == WR_TEMP) begin
            tempResult <= wrData;
         end else if (done && !calThis_r && state_r == S_AUX
                      && tempSlot) begin
            tempResult <= convData - offset_r;
         end
      end
   end

   // Bias lives in a shadow of the nonvolatile byte
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         currentOffsetBias <= BIAS_RST;
      end else if (wrEn && wrSel == WR_BIAS) begin
         currentOffsetBias <= wrData[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Charge accumulation with blanking and saturation
   assign accSum = 33'(chargeAccumulator) + 33'(currClamp);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         chargeAccumulator <= '0;
      end else if (done && !calThis_r && state_r == S_CURR
                   && currMag >= 18'(blankThreshold)) begin
         if (accSum > ACC_MAX) begin
            chargeAccumulator <= ACC_MAX[31:0];
         end else if (accSum < -ACC_MAX) begin
            chargeAccumulator <= 32'(-ACC_MAX);
         end else begin
            chargeAccumulator <= accSum[31:0];
         end
      end
   end

   // Change in relative capacity from counted charge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         capacityDelta <= '0;
      end else begin
         capacityDelta <= 41'(chargeAccumulator) * 41'($signed({1'b0,
            learnedValid ? capScaleLearned : capScaleInitial}));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_sleep_quiet: assert property (
      state_r == S_SLEEP |-> !convStart)
      else $error("conversion started in sleep");
   chk_temp_no_div: assert property (
      state_r == S_AUX && tempSlot |-> !dividerSupplyOut)
      else $error("divider driven during temperature slot");
   chk_div_before_aux: assert property (
      state_r == S_PRE ##1 state_r == S_AUX |-> dividerSupplyOut)
      else $error("divider not on at aux conversion");
   chk_cal_slot: assert property (
      convStart && convCount_r == CAL_SLOT |-> convChan == CH_CAL)
      else $error("calibration slot not taken");
   chk_volt_hold_cal: assert property (
      done && calThis_r && !wrEn |=> $stable(voltResult))
      else $error("voltage changed on calibration");
   chk_curr_hold_cal: assert property (
      done && calThis_r && !wrEn |=> $stable(currResult))
      else $error("current changed on calibration");
   chk_volt_sat: assert property (
      done && !calThis_r && state_r == S_VOLT && voltCorr > VOLT_MAX
      && !wrEn |=> voltResult == POS_FULL)
      else $error("voltage not saturated");
   chk_curr_clamp: assert property (
      done && !calThis_r && state_r == S_CURR && currBiased < CURR_MIN
      && !wrEn |=> currResult == NEG_FULL)
      else $error("current not clamped");
   chk_blank_hold: assert property (
      done && state_r == S_CURR && currMag < 18'(blankThreshold)
      |=> $stable(chargeAccumulator))
      else $error("blanked sample accumulated");
   chk_aux_alt: assert property (
      state_r == S_AUX && done |=> halfSel_r != $past(halfSel_r))
      else $error("aux inputs not alternating");
   chk_bias_write: assert property (
      wrEn && wrSel == WR_BIAS |=> currentOffsetBias == $past(wrData[7:0]))
      else $error("bias write lost");

   cov_temp_slot: cover property (state_r == S_AUX && tempSlot && done);
   cov_cal_conv:  cover property (done && calThis_r);
   cov_full_seq:  cover property (state_r == S_AUX && done && halfSel_r);
endmodule // gauge_measurement_sequencer
`default_nettype wire

// ---- hw/gauge_seq_pkg.sv ----
// Constants and types for the gauge measurement sequencer
package gauge_seq_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1_000_000;
   localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
   // Sequence timing in milliseconds
   localparam int SEQ_MS        = 1760;
   localparam int HALF_MS       = 880;
   localparam int SETTLE_MS     = 2;
   localparam logic [9:0] HALF_TICKS   = 10'(HALF_MS);
   localparam logic [9:0] SETTLE_TICKS = 10'(SETTLE_MS);
   // Offset calibration every 1024th conversion
   localparam logic [9:0] CAL_SLOT = 10'h03_FF;
   // Result codes
   localparam logic [15:0] POS_FULL = 16'h7FFF;
   localparam logic [15:0] NEG_FULL = 16'h8000;
   localparam logic signed [16:0] VOLT_MAX = 17'sh0_0E66;
   localparam logic signed [17:0] CURR_MAX = 18'sh0_07FF;
   localparam logic signed [17:0] CURR_MIN = -18'sh0_0800;
   // Charge limit: 204.8 mVh in 25 uV x 880 ms units
   localparam logic signed [32:0] ACC_MAX = 33'sh0_01FF_5C17;
   // Values after reset
   localparam logic [7:0]  BIAS_RST   = 8'h00;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   // Host write selects
   localparam logic [2:0] WR_VOLT = 3'h0;
   localparam logic [2:0] WR_CURR = 3'h1;
   localparam logic [2:0] WR_AUXA = 3'h2;
   localparam logic [2:0] WR_AUXB = 3'h3;
   localparam logic [2:0] WR_TEMP = 3'h4;
   localparam logic [2:0] WR_BIAS = 3'h5;
   // Converter channels
   typedef enum logic [2:0] {
      CH_VOLT = 3'h0,
      CH_CURR = 3'h1,
      CH_AUXA = 3'h2,
      CH_AUXB = 3'h3,
      CH_TEMP = 3'h4,
      CH_CAL  = 3'h5
   } chan_t;
   // Sequencer states
   typedef enum logic [5:0] {
      S_SLEEP = 6'b00_0001,
      S_WAIT  = 6'b00_0010,
      S_VOLT  = 6'b00_0100,
      S_CURR  = 6'b00_1000,
      S_PRE   = 6'b01_0000,
      S_AUX   = 6'b10_0000
   } state_t;
endpackage

// ---- testbench/conv_partner_model.sv ----
// Behavioural model of the sigma-delta converter beside the sequencer
`timescale 1ns/10ps
`default_nettype none
module conv_partner_model (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // Request side
   input  wire logic        convStart,
   input  wire logic [3:0]  lagCycles,
   input  wire logic [15:0] sampleIn,
   // Answer side
   output logic             convDone,
   output logic [15:0]      convData
);
   logic       busy_r;
   logic [3:0] cnt_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_r   <= 1'b0;
         cnt_r    <= 4'h0;
         convDone <= 1'b0;
         convData <= 16'h0000;
      end else begin
         convDone <= 1'b0;
         // Data is only valid with the done pulse; toggle it otherwise
         convData <= ~convData;
         if (convStart && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r  <= lagCycles;
         end else if (busy_r && cnt_r == 4'h0) begin
            busy_r   <= 1'b0;
            convDone <= 1'b1;
            convData <= sampleIn;
         end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule // conv_partner_model
`default_nettype wire

// ---- testbench/test_gauge_measurement_sequencer.sv ----
// Self-checking bench for the gauge measurement sequencer
`timescale 1ns/10ps
`default_nettype none
module test_gauge_measurement_sequencer;
   import gauge_seq_pkg::*;
   localparam int MS = 10;
   logic clk_sys = 1'b0, rst_n = 1'b0, activeMode = 1'b0, tempSel = 1'b0;
   logic [7:0] thr = 8'h00, capI = 8'h55, capL = 8'h5E;
   logic learnedValid = 1'b0, wrEn = 1'b0;
   logic [2:0] wrSel = 3'h0;
   logic [15:0] wrData = 16'h0000, sampleIn = 16'h0000;
   logic [3:0] lag = 4'h1;
   logic convStart, convDone, divOut;
   chan_t convChan;
   logic [15:0] convData;
   logic signed [15:0] vR, cR, aR, bR, tR;
   logic signed [7:0] biasR;
   logic signed [31:0] accR;
   logic signed [40:0] capD;
   int miscompares = 0, tests_run = 0, settle = 0, seq = 0, pch = 0;
   int accM = 0, biasM = 0, pdat = 0, e = 0, r = 0, h, k, nStart;
   longint cyc = 0, lastV = 0;
   bit pend = 0, nextB = 0, clampPh = 0;
   logic [31:0] seed = 32'd74478;
   chan_t curCh = CH_VOLT, expCh;
   always #5 clk_sys = ~clk_sys;
   gauge_measurement_sequencer #(.MS_CYCLES(MS)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .activeMode(activeMode),
      .internalTempSelect(tempSel), .blankThreshold(thr),
      .capScaleInitial(capI), .capScaleLearned(capL),
      .learnedValid(learnedValid), .wrEn(wrEn), .wrSel(wrSel),
      .wrData(wrData), .convStart(convStart), .convChan(convChan),
      .convDone(convDone), .convData(convData),
      .dividerSupplyOut(divOut), .voltResult(vR), .currResult(cR),
      .auxAResult(aR), .auxBResult(bR), .tempResult(tR),
      .currentOffsetBias(biasR), .chargeAccumulator(accR),
      .capacityDelta(capD));
   conv_partner_model u_conv (
      .clk_sys(clk_sys), .rst_n(rst_n), .convStart(convStart),
      .lagCycles(lag), .sampleIn(sampleIn), .convDone(convDone),
      .convData(convData));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Reference model: sequence order, timing and result arithmetic
   always @(posedge clk_sys) begin
      cyc++;
      settle = divOut ? settle + 1 : 0;
      if (pend) begin
         pend = 0;
         case (pch)
            0: chk(41'(vR), 41'(pdat > 32'sh0E66 ? 32767 : pdat));
            1: begin
               r = biasM - pdat;
               e = r > 2047 ? 32767 : (r < -2048 ? -32768 : r);
               chk(41'(cR), 41'(e));
               if ((r < 0 ? -r : r) >= int'(thr)) accM += e;
               chk(41'(accR), 41'(accM));
            end
            2: chk(41'(aR), 41'(pdat));
            3: chk(41'(bR), 41'(pdat));
            default: chk(41'(tR), 41'(pdat));
         endcase
      end
      if (convDone) begin
         pend = 1;
         pch = int'(curCh);
         pdat = int'($signed(convData));
         if (curCh == CH_TEMP) chk(41'(divOut), 41'(0));
      end
      if (convStart) begin
         expCh = seq == 0 ? CH_VOLT : seq == 1 ? CH_CURR :
                 !nextB ? CH_AUXA : tempSel ? CH_TEMP : CH_AUXB;
         chk(41'(convChan), 41'(expCh));
         curCh = convChan;
         if (seq == 2) nextB = !nextB;
         seq = (seq + 1) % 3;
         if (curCh == CH_VOLT && lastV > 0)
            chk(41'(cyc - lastV), 41'(880 * MS));
         if (curCh == CH_VOLT) lastV = cyc;
         if (curCh == CH_AUXA || curCh == CH_AUXB)
            chk(41'(settle), 41'(SETTLE_MS * MS + 1));
         if (curCh == CH_TEMP) chk(41'(divOut), 41'(0));
         seed = xorshift(seed);
         lag <= 4'(1 + seed[2:0]);
         if (curCh == CH_CURR)
            sampleIn <= clampPh ? (nextB ? 16'h4000 : 16'hC000)
                                : 16'(int'(seed[15:4]) % 3800 - 1900);
         else
            sampleIn <= 16'(seed[15:4]);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Host writes with a one-cycle pulse
   task automatic host_wr(input logic [2:0] sel, input logic [15:0] d);
      wrEn   <= 1'b1;
      wrSel  <= sel;
      wrData <= d;
      @(posedge clk_sys);
      wrEn   <= 1'b0;
      @(posedge clk_sys);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      chk(41'(vR), 41'(0));
      chk(41'(biasR), 41'(BIAS_RST));
      rst_n      <= 1'b1;
      activeMode <= 1'b1;
      for (h = 0; h < 6; h++) begin
         k = 0;
         do begin
            @(posedge clk_sys);
            k++;
         end while (!(convDone && curCh >= CH_AUXA) && k < 20000);
         if (k >= 20000) begin
            miscompares++;
            give_verdict();
         end
         seed = xorshift(seed);
         thr <= seed[7:0];
         if (h == 1) begin
            // Negative bias near the bottom of its range
            host_wr(WR_BIAS, {8'h00, 8'h81});
            biasM = -127;
            chk(41'(biasR), 41'(-127));
         end
         if (h == 2) begin
            chk(41'(capD), 41'(longint'(accM) * 85));
            tempSel <= 1'b1;
         end
         if (h == 3) begin
            // Learned factor and both clamp signs in the last two halves
            learnedValid <= 1'b1;
            clampPh = 1;
         end
         if (h == 4) chk(41'(capD), 41'(longint'(accM) * 94));
      end
      activeMode <= 1'b0;
      repeat (50) @(posedge clk_sys);
      nStart = 0;
      repeat (3000) begin
         @(posedge clk_sys);
         nStart += int'(convStart);
      end
      chk(41'(nStart), 41'(0));
      host_wr(WR_VOLT, 16'h0123);
      chk(41'(vR), 41'(16'h0123));
      host_wr(WR_CURR, 16'h0456);
      chk(41'(cR), 41'(16'h0456));
      host_wr(WR_AUXA, 16'h0789);
      chk(41'(aR), 41'(16'h0789));
      host_wr(WR_AUXB, 16'h0ABC);
      chk(41'(bR), 41'(16'h0ABC));
      host_wr(WR_TEMP, 16'h0DEF);
      chk(41'(tR), 41'(16'h0DEF));
      chk(41'(accR), 41'(accM));
      give_verdict();
   end
endmodule // test_gauge_measurement_sequencer
`default_nettype wire
